//--- shared/fmsp_defs.svh
`ifndef FMSP_DEFS_SVH
`define FMSP_DEFS_SVH

// register addresses on the special function register port
`define FMSP_ADDR_CTRL 8'h98
`define FMSP_ADDR_BUF 8'h99
`define FMSP_CTRL_RESET 8'h00

// control register bit positions
`define FMSP_B_MODE_HI 3'd7
`define FMSP_B_MODE_LO 3'd6
`define FMSP_B_FILTER 3'd5
`define FMSP_B_REN 3'd4
`define FMSP_B_TB8 3'd3
`define FMSP_B_RB8 3'd2
`define FMSP_B_TI 3'd1
`define FMSP_B_RI 3'd0

// timing: shift mode bit is six clocks, async bit is sixteen ticks
`define FMSP_M0_DIV 3'd6
`define FMSP_M0_LAST 3'd5
`define FMSP_M0_HIGH 3'd3
`define FMSP_OVS_LAST 4'd15
`define FMSP_OVS_MID 4'd7
`define FMSP_SYNC_LAST 4'd7

// frame lengths in bits, start bit included for transmit, not for receive
`define FMSP_TX_BITS8 4'd10
`define FMSP_TX_BITS9 4'd11
`define FMSP_RX_BITS8 4'd9
`define FMSP_RX_BITS9 4'd10

`define FMSP_FIFO_DEPTH 4
`define FMSP_DATA_W 8

`endif

//--- shared/fmsp_pkg.sv
package fmsp_pkg;
    typedef enum logic [1:0] {
        FMSP_SHIFT,
        FMSP_UART8,
        FMSP_UART9F,
        FMSP_UART9V
    } fmsp_mode_t;
    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} fmsp_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SYNC} fmsp_rx_st_t;
    typedef logic [7:0] fmsp_byte_t;
endpackage

//--- rtl/fmsp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module fmsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic full_r;
    logic empty_r;
    wire push = in_valid && !full_r;
    wire pop = out_ready && !empty_r;
    wire [AW:0] count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

    assign in_ready = !full_r;
    assign out_valid = !empty_r;
    assign out_data = mem_r[rd_ptr_r];

    // pointers wrap by hand so depths that are not a power of two still work
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            full_r <= 1'b0;
            empty_r <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_nxt;
            full_r <= (count_nxt == (AW+1)'(DEPTH));
            empty_r <= (count_nxt == '0);
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end
endmodule
`default_nettype wire

//--- rtl/fmsp_top.sv
// Operation
// - transmitter and receiver run at the same time in modes 1 to 3, each on its own state; in mode 0 one waits for the other
// - buffer write feeds transmit; buffer read returns the separate receive register
// - four modes chosen by the two mode-select bits
// - mode 0: data in and out on rxd, txd is shift clock, 8 bits lsb first
// - mode 0 bit rate is clock divided by six
// - mode 1 frame: start 0, eight data lsb first, stop 1
// - mode 1 receive stores stop bit in received ninth bit
// - mode 1 bit rate comes from baud timer overflows
// - mode 2 frame: start, eight data, ninth from transmit ninth bit, stop
// - mode 2 receive stores ninth bit, stop bit not stored
// - mode 2 bit rate is clock over sixteen or thirty-two by baud double
// - mode 3 equals mode 2 but rate comes from baud timer
// - any buffer write queues a transmission in every mode, except a write while the four-entry queue is full, which is dropped
// - mode 0 receive starts when receive flag is 0 and receive enable is 1
// - async receive starts on a start bit only while receive enable is 1
// - control bit 7 is mode_sel_hi or framing error as bit7_select picks
// - missing stop bit sets framing error, sticky until software clears it
// - control register bit addressable, resets to zero, fixed field order
// - baud timer overflows keep clocking the port whatever the timers do
// - mode bits decode 00 shift, 01 8-bit, 10 9-bit fixed, 11 9-bit variable
// - transmit flag set after bit 8 in mode 0, at stop start otherwise
// - receive flag set after bit 8 in mode 0, mid stop bit otherwise
// - multiproc filter blocks receive flag on ninth 0, or mode 1 bad stop
`include "fmsp_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module fmsp_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire fmsp_pkg::fmsp_byte_t sfr_wdata,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_idx,
    input wire logic sfr_bit_val,
    output fmsp_pkg::fmsp_byte_t sfr_rdata,
    input wire logic bit7_select,
    input wire logic baud_double,
    input wire logic baud_timer_ovf,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd,
    output logic tx_buf_ready
);
    import fmsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // control register and register port
    logic [1:0] mode_bits_r;
    logic filter_r, ren_r, tb8_r, rb8_r, ti_r, ri_r, fe_r;
    fmsp_byte_t rbuf_r, rdata_r;
    fmsp_mode_t mode;
    logic ti_set, ri_set, fe_set, rx_load;
    logic rb8_val;
    fmsp_byte_t rx_byte;

    always_comb begin
        unique case (mode_bits_r)
            2'b00: mode = FMSP_SHIFT;
            2'b01: mode = FMSP_UART8;
            2'b10: mode = FMSP_UART9F;
            2'b11: mode = FMSP_UART9V;
        endcase
    end

    wire bit7_view = bit7_select ? fe_r : mode_bits_r[1];
    wire [7:0] ctrl_view = {bit7_view, mode_bits_r[0], filter_r, ren_r,
                            tb8_r, rb8_r, ti_r, ri_r};
    wire sel_ctrl = (sfr_addr == `FMSP_ADDR_CTRL);
    wire sel_buf = (sfr_addr == `FMSP_ADDR_BUF);
    wire [7:0] bit_mask = 8'h01 << sfr_bit_idx;
    // a bit write is a read-modify-write of the current view
    wire [7:0] ctrl_new = sfr_bit_wr ?
        ((ctrl_view & ~bit_mask) | (sfr_bit_val ? bit_mask : 8'h00)) : sfr_wdata;
    wire ctrl_we = sel_ctrl && (sfr_wr || sfr_bit_wr);
    wire buf_we = sel_buf && sfr_wr;
    wire [7:0] rd_mux = sel_ctrl ? ctrl_view : (sel_buf ? rbuf_r : 8'h00);

    always_ff @(posedge clock) begin
        if (rst) begin
            {mode_bits_r, filter_r, ren_r, tb8_r} <= 5'(`FMSP_CTRL_RESET >> 3);
            fe_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            if (ctrl_we) begin
                if (!bit7_select) mode_bits_r[1] <= ctrl_new[`FMSP_B_MODE_HI];
                mode_bits_r[0] <= ctrl_new[`FMSP_B_MODE_LO];
                filter_r <= ctrl_new[`FMSP_B_FILTER];
                ren_r <= ctrl_new[`FMSP_B_REN];
                tb8_r <= ctrl_new[`FMSP_B_TB8];
            end
            // hardware set wins over a software clear in the same cycle
            if (fe_set) fe_r <= 1'b1;
            else if (ctrl_we && bit7_select) fe_r <= ctrl_new[`FMSP_B_MODE_HI];
            if (sfr_rd) rdata_r <= rd_mux;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ti_r <= 1'b0;
            ri_r <= 1'b0;
            rb8_r <= 1'b0;
            rbuf_r <= 8'h00;
        end else begin
            if (ti_set) ti_r <= 1'b1;
            else if (ctrl_we) ti_r <= ctrl_new[`FMSP_B_TI];
            if (ri_set) ri_r <= 1'b1;
            else if (ctrl_we) ri_r <= ctrl_new[`FMSP_B_RI];
            if (rx_load) rb8_r <= rb8_val;
            else if (ctrl_we) rb8_r <= ctrl_new[`FMSP_B_RB8];
            if (rx_load) rbuf_r <= rx_byte;
        end
    end
    assign sfr_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // rate generation
    logic half_r;
    logic [2:0] m0_phase_r;
    wire fixed_rate = (mode == FMSP_UART9F);
    // mode 2 draws one pulse per clock, modes 1 and 3 one per timer overflow
    wire tick_src = fixed_rate ? 1'b1 : baud_timer_ovf;
    wire tick = tick_src && (baud_double || half_r);
    wire m0_last = (m0_phase_r == `FMSP_M0_LAST);

    always_ff @(posedge clock) begin
        if (rst) begin
            half_r <= 1'b0;
            m0_phase_r <= 3'd0;
        end else begin
            if (tick_src) half_r <= !half_r;
            m0_phase_r <= m0_last ? 3'd0 : m0_phase_r + 3'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit path: queue, then shifter
    logic fifo_valid, fifo_pop;
    fmsp_byte_t fifo_data;

    fmsp_fifo #(
        .WIDTH(`FMSP_DATA_W),
        .DEPTH(`FMSP_FIFO_DEPTH)
    ) u_txq (
        .clock(clock),
        .rst(rst),
        .in_valid(buf_we),
        .in_ready(tx_buf_ready),
        .in_data(sfr_wdata),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    fmsp_tx_st_t tx_st_r, tx_st_nxt;
    fmsp_rx_st_t rx_st_r;
    logic [3:0] rbit_r, rcnt_r, rx_bits_r;
    logic [10:0] tsh_r, tsh_nxt;
    logic [3:0] tbit_r, tbit_nxt, tcnt_r, tcnt_nxt;
    logic txd_r, rxd_out_r, rxd_oe_r;
    logic [3:0] tx_bits_r;
    wire is_sync = (mode == FMSP_SHIFT);
    wire nine_bit = mode_bits_r[1];
    // shift transfers start on a phase boundary so the clock has full halves
    wire sync_start_ok = m0_last && rx_st_r != RX_SYNC;
    wire rx_sync_go = (rx_st_r == RX_IDLE) && is_sync && ren_r && !ri_r &&
                      (tx_st_r == TX_IDLE) && !fifo_valid && m0_last;
    // clock follows the next receive state so the last bit leaves no stray fall
    wire rx_sync_nxt = rx_sync_go ||
                       ((rx_st_r == RX_SYNC) && !(m0_last && rbit_r == `FMSP_SYNC_LAST));

    always_comb begin
        tx_st_nxt = tx_st_r;
        tsh_nxt = tsh_r;
        tbit_nxt = tbit_r;
        tcnt_nxt = tcnt_r;
        fifo_pop = 1'b0;
        ti_set = 1'b0;
        unique case (tx_st_r)
            TX_IDLE: begin
                if (fifo_valid && !is_sync) begin
                    fifo_pop = 1'b1;
                    tx_st_nxt = TX_ASYNC;
                    // stop bit, ninth bit (or a second stop), data, start bit
                    tsh_nxt = {1'b1, nine_bit ? tb8_r : 1'b1, fifo_data, 1'b0};
                    tbit_nxt = 4'd0;
                    tcnt_nxt = 4'd0;
                end else if (fifo_valid && sync_start_ok) begin
                    fifo_pop = 1'b1;
                    tx_st_nxt = TX_SYNC;
                    tsh_nxt = {3'b111, fifo_data};
                    tbit_nxt = 4'd0;
                end
            end
            TX_ASYNC: begin
                if (tick) begin
                    tcnt_nxt = tcnt_r + 4'd1;
                    if (tcnt_r == `FMSP_OVS_LAST) begin
                        tsh_nxt = {1'b1, tsh_r[10:1]};
                        tbit_nxt = tbit_r + 4'd1;
                        if (tbit_r + 4'd1 == tx_bits_r - 4'd1) ti_set = 1'b1;
                        if (tbit_r + 4'd1 == tx_bits_r) tx_st_nxt = TX_IDLE;
                    end
                end
            end
            TX_SYNC: begin
                if (m0_last) begin
                    tsh_nxt = {1'b1, tsh_r[10:1]};
                    tbit_nxt = tbit_r + 4'd1;
                    if (tbit_r == `FMSP_SYNC_LAST) begin
                        ti_set = 1'b1;
                        tx_st_nxt = TX_IDLE;
                    end
                end
            end
            default: tx_st_nxt = TX_IDLE;
        endcase
    end

    wire sync_clk_nxt = (m0_phase_r == `FMSP_M0_LAST) || (m0_phase_r < 3'd2);
    wire tx_sync_nxt = (tx_st_nxt == TX_SYNC);

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_st_r <= TX_IDLE;
            tsh_r <= 11'h7ff;
            tbit_r <= 4'd0;
            tcnt_r <= 4'd0;
            tx_bits_r <= `FMSP_TX_BITS8;
            txd_r <= 1'b1;
            rxd_out_r <= 1'b1;
            rxd_oe_r <= 1'b0;
        end else begin
            tx_st_r <= tx_st_nxt;
            tsh_r <= tsh_nxt;
            tbit_r <= tbit_nxt;
            tcnt_r <= tcnt_nxt;
            if (tx_st_r == TX_IDLE) tx_bits_r <= nine_bit ? `FMSP_TX_BITS9 : `FMSP_TX_BITS8;
            // in shift mode txd is low for the first half of each bit
            if (tx_sync_nxt || rx_sync_nxt) txd_r <= !sync_clk_nxt;
            else if (tx_st_nxt == TX_ASYNC) txd_r <= tsh_nxt[0];
            else txd_r <= 1'b1;
            rxd_out_r <= tx_sync_nxt ? tsh_nxt[0] : 1'b1;
            rxd_oe_r <= tx_sync_nxt;
        end
    end
    assign txd = txd_r;
    assign rxd_out = rxd_out_r;
    assign rxd_oe = rxd_oe_r;

    ////////////////////////////////////////////////////////////////////////
    // receive path
    logic rxd_s1_r, rxd_s2_r, rxd_s3_r;
    logic [9:0] rsh_r;
    logic rx_nine_r;
    wire start_edge = rxd_s3_r && !rxd_s2_r;
    wire [9:0] rsh_new = {rxd_s2_r, rsh_r[9:1]};
    wire stop_bit = rxd_s2_r;
    wire ninth = rx_nine_r ? rsh_new[8] : stop_bit;
    wire rx_pass = !(filter_r && !ninth);
    wire async_done = (rx_st_r == RX_DATA) && tick && (rcnt_r == `FMSP_OVS_LAST) &&
                      (rbit_r + 4'd1 == rx_bits_r);
    wire sync_done = (rx_st_r == RX_SYNC) && m0_last && (rbit_r == `FMSP_SYNC_LAST);

    assign rx_load = (async_done && rx_pass) || sync_done;
    assign ri_set = rx_load;
    assign fe_set = async_done && !stop_bit;
    assign rb8_val = sync_done ? rb8_r : ninth;
    assign rx_byte = sync_done ? rsh_new[9:2] :
                     (rx_nine_r ? rsh_new[7:0] : rsh_new[8:1]);

    always_ff @(posedge clock) begin
        if (rst) begin
            rxd_s1_r <= 1'b1;
            rxd_s2_r <= 1'b1;
            rxd_s3_r <= 1'b1;
        end else begin
            rxd_s1_r <= rxd_in;
            rxd_s2_r <= rxd_s1_r;
            rxd_s3_r <= rxd_s2_r;
        end
    end

    // receive runs beside transmit with its own counters
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_st_r <= RX_IDLE;
            rsh_r <= 10'h000;
            rbit_r <= 4'd0;
            rcnt_r <= 4'd0;
            rx_bits_r <= `FMSP_RX_BITS8;
            rx_nine_r <= 1'b0;
        end else begin
            unique case (rx_st_r)
                RX_IDLE: begin
                    rbit_r <= 4'd0;
                    rcnt_r <= 4'd0;
                    rx_nine_r <= nine_bit;
                    rx_bits_r <= nine_bit ? `FMSP_RX_BITS9 : `FMSP_RX_BITS8;
                    if (!is_sync && ren_r && start_edge) rx_st_r <= RX_START;
                    else if (rx_sync_go) rx_st_r <= RX_SYNC;
                end
                RX_START: if (tick) begin
                    rcnt_r <= rcnt_r + 4'd1;
                    if (rcnt_r == `FMSP_OVS_MID) begin
                        // a glitch shorter than half a bit is not a start bit
                        rx_st_r <= rxd_s2_r ? RX_IDLE : RX_DATA;
                        rcnt_r <= 4'd0;
                    end
                end
                RX_DATA: if (tick) begin
                    rcnt_r <= rcnt_r + 4'd1;
                    if (rcnt_r == `FMSP_OVS_LAST) begin
                        rsh_r <= rsh_new;
                        rbit_r <= rbit_r + 4'd1;
                        if (async_done) rx_st_r <= RX_IDLE;
                    end
                end
                RX_SYNC: if (m0_last) begin
                    // sample at the end of the bit, on the same edge that drops the shift clock
                    rsh_r <= rsh_new;
                    rbit_r <= rbit_r + 4'd1;
                    if (sync_done) rx_st_r <= RX_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- tb/fmsp_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module fmsp_monitor
    import fmsp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire fmsp_pkg::fmsp_byte_t sfr_rdata,
    input wire logic tx_buf_ready,
    input wire logic rxd_out,
    input wire logic rxd_oe,
    input wire logic txd,
    input wire fmsp_pkg::fmsp_byte_t sfr_wdata,
    input wire logic bit7_select
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire logic buf_wr = sfr_wr && sfr_addr == 8'h99;
    // mode as set by byte writes; bit writes to the mode bits are not followed
    logic [1:0] mode_seen_r;
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_seen_r <= 2'b00;
        end else if (sfr_wr && sfr_addr == 8'h98) begin
            mode_seen_r <= {bit7_select ? mode_seen_r[1] : sfr_wdata[7], sfr_wdata[6]};
        end
    end
    ////////////////////////////////////////////////////////////////
    a_reset_idle:
        assert property (disable iff (1'b0) rst |=> txd && rxd_out && !rxd_oe)
        else $error("pins not idle after reset");
    a_ctrl_zero:
        assert property ($fell(rst) && sfr_rd && sfr_addr == 8'h98 |=> sfr_rdata == 8'h00)
        else $error("control not zero after reset");
    a_rdata_holds:
        assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero:
        assert property (sfr_rd && sfr_addr != 8'h98 && sfr_addr != 8'h99 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    // ready may be registered one stage late, so allow either depth
    a_ready_cause:
        assert property ($fell(tx_buf_ready) |-> $past(buf_wr) || $past(buf_wr, 2))
        else $error("queue filled without a buffer write");
    a_shift_low:
        assert property (rxd_oe && $fell(txd) |-> !txd [*3] ##1 txd)
        else $error("shift clock low phase not three clocks");
    a_shift_high:
        assert property (rxd_oe && $rose(txd) |-> txd [*3])
        else $error("shift clock high phase too short");
    a_shift_data:
        assert property (rxd_oe && $past(rxd_oe) && !$fell(txd) |-> $stable(rxd_out))
        else $error("shift data moved off the clock fall");
    a_start_long:
        assert property (mode_seen_r != 2'b00 && !rxd_oe && $fell(txd) |-> !txd [*8])
        else $error("start bit too short");
endmodule
bind fmsp_top fmsp_monitor u_monitor (
    .clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .tx_buf_ready(tx_buf_ready), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd(txd), .sfr_wdata(sfr_wdata), .bit7_select(bit7_select)
);
`default_nettype wire

//--- tb/fmsp_peer.sv
`timescale 1ns/1ns
`default_nettype none
module fmsp_peer (
    input wire logic clock,
    input wire logic txd,
    input wire logic rxd_oe,
    input wire logic rxd_out,
    output logic rxd_in
);
    int bit_clocks = 32;
    int nbits = 9;
    logic shift_mode = 1'b0;
    logic line_r = 1'b1;
    logic [7:0] shift_src = 8'h00;
    logic [7:0] sh_in = 8'h00;
    logic [9:0] v;
    logic [9:0] got_q[$];
    // the device owns the wire whenever its driver is on
    assign rxd_in = rxd_oe ? rxd_out : line_r;
    ////////////////////////////////////////////////////////////////
    task automatic send(input logic [8:0] bits, input logic stop);
        line_r = 1'b0;
        repeat (bit_clocks) @(negedge clock);
        for (int i = 0; i < nbits; i++) begin
            line_r = bits[i];
            repeat (bit_clocks) @(negedge clock);
        end
        line_r = stop;
        repeat (bit_clocks) @(negedge clock);
        line_r = 1'b1;
        // one idle clock so a following frame never drives the line twice at once
        @(negedge clock);
    endtask
    // shift peripheral: new bit on clock fall, used bits come back inverted
    always @(negedge txd) if (shift_mode && !rxd_oe) begin
        line_r = shift_src[0];
        shift_src = {~shift_src[0], shift_src[7:1]};
    end
    always @(posedge txd) if (shift_mode && rxd_oe) sh_in = {rxd_out, sh_in[7:1]};
    initial forever begin
        @(negedge txd);
        if (!shift_mode) begin
            v = 10'h000;
            repeat (bit_clocks / 2) @(posedge clock);
            for (int i = 0; i <= nbits; i++) begin
                repeat (bit_clocks) @(posedge clock);
                v[i] = txd;
            end
            got_q.push_back(v);
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_four_mode_serial_port.sv
`timescale 1ns/1ns
`default_nettype none
module tb_four_mode_serial_port;
    import fmsp_pkg::*;
    logic clock = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, sfr_bit_wr = 0, sfr_bit_val = 0;
    logic bit7_select = 0, baud_double = 0, baud_timer_ovf = 0;
    logic rxd_in, rxd_out, rxd_oe, txd, tx_buf_ready;
    logic [7:0] sfr_addr = 8'h00;
    logic [2:0] sfr_bit_idx = 3'h0;
    fmsp_byte_t sfr_wdata = 8'h00, sfr_rdata, rv, d, e;
    int mismatches = 0, compares = 0;
    always #10 clock = ~clock;
    always @(negedge clock) baud_timer_ovf <= ~baud_timer_ovf;
    fmsp_top DUT (.clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
        .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
        .bit7_select(bit7_select), .baud_double(baud_double),
        .baud_timer_ovf(baud_timer_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe), .txd(txd), .tx_buf_ready(tx_buf_ready));
    fmsp_peer peer (.clock(clock), .txd(txd), .rxd_oe(rxd_oe), .rxd_out(rxd_out),
        .rxd_in(rxd_in));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input fmsp_byte_t dv);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = dv;
        sfr_wr = 1;
        @(negedge clock);
        sfr_wr = 0;
    endtask
    task automatic bw(input logic [2:0] idx, input logic val);
        @(negedge clock);
        sfr_addr = 8'h98;
        sfr_bit_idx = idx;
        sfr_bit_val = val;
        sfr_bit_wr = 1;
        @(negedge clock);
        sfr_bit_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        sfr_addr = a;
        sfr_rd = 1;
        @(negedge clock);
        sfr_rd = 0;
        rv = sfr_rdata;
    endtask
    // polling is bounded so a flag that never comes ends the run
    task automatic wait_flag(input int b);
        for (int i = 0; i < 400; i++) begin
            rd(8'h98);
            if (rv[b] === 1'b1) return;
        end
        mismatches++;
        give_verdict();
    endtask
    task automatic take_frame(input logic [9:0] exp);
        for (int i = 0; i < 800 && peer.got_q.size() == 0; i++) @(negedge clock);
        if (peer.got_q.size() == 0) begin
            mismatches++;
            give_verdict();
        end else begin
            check(peer.got_q.pop_front(), exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge clock);
        rst = 0;
        sfr_rd = 1;
        sfr_addr = 8'h98;
        @(negedge clock);
        sfr_rd = 0;
        check(sfr_rdata, 8'h00);
        rd(8'h9a);
        check(rv, 8'h00);
        wr(8'h98, 8'h40);
        bit7_select = 1;
        bw(3'h7, 1'b1);
        rd(8'h98);
        check(rv, 8'hc0);
        bit7_select = 0;
        rd(8'h98);
        check(rv, 8'h40);
        bit7_select = 1;
        bw(3'h7, 1'b0);
        bit7_select = 0;
        for (int m = 1; m < 4; m++) begin
            // mode 1 runs undoubled so the divided timer tick is exercised
            baud_double = (m == 3);
            peer.bit_clocks = (m == 1) ? 64 : 32;
            peer.nbits = (m == 1) ? 8 : 9;
            d = {6'h0c, m[1:0]};
            e = {6'h29, m[1:0]};
            wr(8'h98, {m[1:0], 6'h18});
            fork
                wr(8'h99, d);
                peer.send({m[0], e}, 1'b1);
            join
            wait_flag(1);
            wait_flag(0);
            check(rv[2], (m == 1) ? 1'b1 : m[0]);
            rd(8'h99);
            check(rv, e);
            take_frame((m == 1) ? {2'b01, d} : {2'b11, d});
        end
        peer.nbits = 8;
        baud_double = 1;
        wr(8'h98, 8'h70);
        peer.send(9'h011, 1'b0);
        rd(8'h98);
        check(rv[0], 1'b0);
        peer.send(9'h022, 1'b1);
        peer.send(9'h033, 1'b1);
        bit7_select = 1;
        rd(8'h98);
        check(rv, 8'hf5);
        rd(8'h99);
        check(rv, 8'h33);
        bw(3'h7, 1'b0);
        bit7_select = 0;
        peer.nbits = 9;
        baud_double = 0;
        wr(8'h98, 8'hb0);
        peer.send(9'h044, 1'b1);
        rd(8'h98);
        check(rv[0], 1'b0);
        peer.send(9'h155, 1'b1);
        rd(8'h98);
        check(rv[0], 1'b1);
        peer.shift_mode = 1;
        wr(8'h98, 8'h00);
        wr(8'h99, 8'h96);
        wait_flag(1);
        check(peer.sh_in, 8'h96);
        peer.shift_src = 8'h3c;
        wr(8'h98, 8'h10);
        wait_flag(0);
        rd(8'h99);
        check(rv, 8'h3c);
        peer.shift_mode = 0;
        peer.bit_clocks = 16;
        baud_double = 1;
        wr(8'h98, 8'h88);
        for (int i = 0; i < 6; i++) wr(8'h99, {5'h00, i[2:0]});
        check(tx_buf_ready, 1'b0);
        for (int i = 0; i < 5; i++) take_frame({5'h18, i[4:0]});
        // one full frame of 176 clocks is long enough for a dropped sixth to show
        repeat (200) @(negedge clock);
        check(peer.got_q.size(), 0);
        check(tx_buf_ready, 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
